// *** apc_params.svh ***
// constants for the audio pwm control register group: offsets, field positions,
// reset values and automute timing.
// assumes a 25 MHz core clock and an I2C control port bringing the host in.
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH

// core clock period in nanoseconds
`define APC_CLK_NS 40

// register offsets on the control port sub-address space
`define APC_OFS_HP_CFG 8'h0D
`define APC_OFS_SER_FMT 8'h0E
`define APC_OFS_MUTE 8'h0F
`define APC_OFS_FLAGS 8'h10
`define APC_OFS_AM_CTL 8'h14

// headphone configuration fields
`define APC_HP_BKND_RST_BIT 7
`define APC_HP_VALID_LOW_BIT 6
`define APC_HP_WR_MASK 8'hFE

// energy flag positions
`define APC_FLG_SAT_LOW 0
`define APC_FLG_SAT_HIGH 1
`define APC_FLG_SUB_LOW 2
`define APC_FLG_SUB_HIGH 3

// serial word format codes
`define APC_FMT_LAST_LEGAL 4'h8
`define APC_FMT_PER_JUSTIFY 4'h3

// reset values
`define APC_RST_HP_CFG 8'h00
`define APC_RST_SER_FMT 8'h05
`define APC_RST_MUTE 8'h00
`define APC_RST_AM_CTL 8'h00

// automute delays are whole multiples of this step (2.98 ms is two steps)
`define APC_AM_STEP_NS 1490000
// input automute thresholds in dBFS
`define APC_THR_MIN_DBFS 8'hA6
`define APC_THR_STEP_DB 8'h06
`define APC_THR_CODE7_DBFS 8'hD0
`define APC_THR_CODE8_DBFS 8'hD6

// neutral default 7-bit control port address, value is arbitrary
`define APC_DEV_ADDR 7'h2A

`endif

// *** apc_pkg.sv ***
// types shared by the audio pwm control register group.
// assumes apc_params.svh is on the include path.
package apc_pkg;
  `include "apc_params.svh"

  // serial word justification
  typedef enum logic [1:0] {APC_RIGHT_JUST, APC_I2S, APC_LEFT_JUST} apc_justify_type;

  // serial word format as handed to the serial ports
  typedef struct packed {
    apc_justify_type justify;
    logic [4:0] word_bits;
  } apc_fmt_type;

  // control port transfer phase
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_SUB, I2C_WDAT, I2C_RDAT} apc_i2c_type;

  // whole state of the block
  typedef struct packed {
    logic scl_a;
    logic scl_b;
    logic scl_p;
    logic sda_a;
    logic sda_b;
    logic sda_p;
    apc_i2c_type ph;
    logic ackph;
    logic mack;
    logic rnw;
    logic sda_drv;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] sub;
    logic [7:0] hp_cfg;
    logic [7:0] ser_fmt;
    logic [7:0] mute;
    logic [3:0] flags;
    logic [7:0] am_ctl;
    apc_fmt_type fmt;
    logic [7:0] thr;
    logic [15:0] tick;
    logic [6:0] am_cnt;
    logic am_on;
    logic hp_go;
    logic hp_valid;
  } apc_state_type;
endpackage

// *** apc_regs.sv ***
// control and status registers of the eight channel audio pwm processor,
// reached by a host over the I2C control port (7-bit address, sub-address, data).
// assumes scl/sda come straight from pins; all other inputs are on clk.
// assumes a host that keeps each clock phase at least four core cycles long.
`timescale 1ns/100ps
`include "apc_params.svh"

// What this block does
// - headphone reset sequence runs only when D7 set
// - D6 low: valid follows headphone switching
// - nine serial word formats, set over I2C
// - codes 0-8 map formats; 9-15 illegal
// - same format for serial out and input five
// - one soft mute bit per channel
// - D0 flags satellite energy below low
// - D1 flags satellite energy above high
// - D2 flags sub-woofer energy below low
// - D3 flags sub-woofer energy above high
// - energy flags sticky, cleared by writing zero
// - delay codes 0-3 give 2.98-7.45 ms
// - codes 4-15 give 14.9 ms steps
// - threshold codes 0-6 give -90 to -54
// - threshold code 8 gives -42, 9-15 reserved
// - a -48 dBFS threshold is offered
// - thresholds relative to full scale, approximate
module apc_regs #(
  parameter logic [6:0] DEV_ADDR = `APC_DEV_ADDR,
  parameter int unsigned AM_STEP_CYCLES = `APC_AM_STEP_NS / `APC_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic hp_mode,
  input wire logic hp_switching,
  input wire logic hp_backend_reset_req,
  output logic hp_backend_reset_go,
  output logic hp_valid,
  input wire logic sat_low_evt,
  input wire logic sat_high_evt,
  input wire logic sub_low_evt,
  input wire logic sub_high_evt,
  output logic [7:0] channel_mute,
  output apc_pkg::apc_fmt_type serial_audio_out_fmt,
  output apc_pkg::apc_fmt_type fifth_serial_audio_in_fmt,
  input wire logic signed [7:0] in_level_dbfs,
  output logic signed [7:0] automute_threshold_dbfs,
  output logic automute_active
);

  // registered and next state
  apc_pkg::apc_state_type st_q;
  apc_pkg::apc_state_type st_d;

  // decode a legal format code into justification and word length
  // codes above 8 never get here, the write filter turns them away
  function automatic apc_pkg::apc_fmt_type fmt_dec(input logic [3:0] code);
    apc_pkg::apc_fmt_type f;
    logic [3:0] rem;
    f.justify = apc_pkg::APC_RIGHT_JUST;
    rem = code;
    if (code >= 4'h6) begin
      f.justify = apc_pkg::APC_LEFT_JUST;
      rem = code - 4'h6;
    end else if (code >= `APC_FMT_PER_JUSTIFY) begin
      f.justify = apc_pkg::APC_I2S;
      rem = code - `APC_FMT_PER_JUSTIFY;
    end
    // 16, 20 or 24 bits within each justification
    f.word_bits = 5'h10 + {1'b0, rem[1:0], 2'b00};
    return f;
  endfunction

  // automute delay in 1.49 ms steps for each delay code
  // codes 0-3 count 2 to 5 steps, codes 4-15 count ten steps per code
  function automatic logic [6:0] delay_steps(input logic [3:0] code);
    logic [6:0] s;
    if (code < 4'h4) begin
      s = {3'h0, code} + 7'h02;
    end else begin
      s = 7'((code - 4'h3) * 10);
    end
    return s;
  endfunction

  // input automute threshold in dBFS for each threshold code
  // codes 0-6 climb from -90 dBFS in 6 dB steps
  function automatic logic [7:0] thr_dec(input logic [3:0] code);
    logic [7:0] t;
    if (code < 4'h7) begin
      t = `APC_THR_MIN_DBFS + 8'(code * `APC_THR_STEP_DB);
    end else if (code == 4'h7) begin
      t = `APC_THR_CODE7_DBFS;
    end else begin
      // reserved codes behave as the highest legal level
      t = `APC_THR_CODE8_DBFS;
    end
    return t;
  endfunction

  // register read mux; unmapped sub-addresses read zero
  // reads have no side effects, so a read burst may run past the group
  function automatic logic [7:0] reg_rd(input apc_pkg::apc_state_type s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `APC_OFS_HP_CFG: v = s.hp_cfg;
      `APC_OFS_SER_FMT: v = s.ser_fmt;
      `APC_OFS_MUTE: v = s.mute;
      `APC_OFS_FLAGS: v = {4'h0, s.flags};
      `APC_OFS_AM_CTL: v = s.am_ctl;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // next-state logic for the control port, registers and automute timer
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [3:0] clr;
    logic [3:0] evt;
    logic quiet;
    logic tick_wrap;
    // every local gets a value first so that no path leaves one unassigned
    st_d = st_q;
    clr = 4'h0;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    evt = 4'h0;
    quiet = 1'b0;
    tick_wrap = 1'b0;
    // pin synchronisers: first stage feeds only the second
    st_d.scl_a = scl_in;
    st_d.scl_b = st_q.scl_a;
    st_d.scl_p = st_q.scl_b;
    st_d.sda_a = sda_in;
    st_d.sda_b = st_q.sda_a;
    st_d.sda_p = st_q.sda_b;
    // edges are judged on the second stage and its delayed copy, so a glitch
    // caught by the first stage still reaches the sequencer one cycle later
    scl_rise = st_q.scl_b & ~st_q.scl_p;
    scl_fall = ~st_q.scl_b & st_q.scl_p;
    // start: data falls while the clock stays high
    start_c = st_q.scl_b & st_q.scl_p & st_q.sda_p & ~st_q.sda_b;
    // stop: data rises while the clock stays high
    stop_c = st_q.scl_b & st_q.scl_p & ~st_q.sda_p & st_q.sda_b;

    // control port sequencing
    if (start_c) begin
      // a start aborts whatever transfer was running
      // a repeated start keeps the sub-address
      st_d.ph = apc_pkg::I2C_ADDR;
      st_d.cnt = 4'h0;
      st_d.ackph = 1'b0;
      st_d.mack = 1'b0;
      st_d.sda_drv = 1'b0;
    end else if (stop_c) begin
      // stop: let go of the bus and wait for the next start
      st_d.ph = apc_pkg::I2C_IDLE;
      st_d.ackph = 1'b0;
      st_d.mack = 1'b0;
      st_d.sda_drv = 1'b0;
    end else if (st_q.ph != apc_pkg::I2C_IDLE) begin
      if (scl_rise) begin
        // the master's acknowledge slot of a read
        if (st_q.mack) begin
          // master nack ends the read burst
          if (st_q.sda_b) begin
            st_d.ph = apc_pkg::I2C_IDLE;
            st_d.mack = 1'b0;
          end
        end else if (!st_q.ackph) begin
          // a data bit: count it, and shift it in unless we are the sender
          st_d.cnt = st_q.cnt + 4'h1;
          if (st_q.ph != apc_pkg::I2C_RDAT) begin
            st_d.sh = {st_q.sh[6:0], st_q.sda_b};
          end
        end
      end else if (scl_fall) begin
        if (st_q.ackph || st_q.mack) begin
          // our ack slot or the master's is over
          st_d.ackph = 1'b0;
          st_d.mack = 1'b0;
          st_d.sda_drv = 1'b0;
          st_d.cnt = 4'h0;
          if ((st_q.ph == apc_pkg::I2C_ADDR && st_q.rnw) || st_q.ph == apc_pkg::I2C_RDAT) begin
            // load the next read byte and present its top bit
            st_d.ph = apc_pkg::I2C_RDAT;
            st_d.sh = reg_rd(st_q, st_q.sub);
            st_d.sda_drv = ~st_d.sh[7];
            st_d.sub = st_q.sub + 8'h01;
          end else if (st_q.ph == apc_pkg::I2C_ADDR) begin
            // write: the sub-address comes next
            st_d.ph = apc_pkg::I2C_SUB;
          end else begin
            // after the sub-address or a data byte, more data follows
            st_d.ph = apc_pkg::I2C_WDAT;
          end
        end else if (st_q.ph == apc_pkg::I2C_RDAT) begin
          if (st_q.cnt == 4'h8) begin
            // release for the master's acknowledge
            st_d.sda_drv = 1'b0;
            st_d.mack = 1'b1;
          end else begin
            // next bit goes out while the clock is low
            st_d.sh = {st_q.sh[6:0], 1'b0};
            st_d.sda_drv = ~st_q.sh[6];
          end
        end else if (st_q.cnt == 4'h8) begin
          // a whole byte has arrived
          st_d.ackph = 1'b1;
          st_d.sda_drv = 1'b1;
          unique case (st_q.ph)
            apc_pkg::I2C_ADDR: begin
              // the lowest address bit chooses read or write
              st_d.rnw = st_q.sh[0];
              if (st_q.sh[7:1] != DEV_ADDR) begin
                // not ours: stay off the bus until the next start
                st_d.ph = apc_pkg::I2C_IDLE;
                st_d.ackph = 1'b0;
                st_d.sda_drv = 1'b0;
              end
            end
            // the sub-address byte picks where the next data lands
            apc_pkg::I2C_SUB: st_d.sub = st_q.sh;
            default: begin
              // data byte: write, then step to the next sub-address
              st_d.sub = st_q.sub + 8'h01;
              unique case (st_q.sub)
                `APC_OFS_HP_CFG: begin
                  st_d.hp_cfg = st_q.sh & `APC_HP_WR_MASK;
                end
                `APC_OFS_SER_FMT: begin
                  // illegal codes are not taken, the old format stays
                  if (st_q.sh[3:0] <= `APC_FMT_LAST_LEGAL) begin
                    st_d.ser_fmt = {4'h0, st_q.sh[3:0]};
                    st_d.fmt = fmt_dec(st_q.sh[3:0]);
                  end
                end
                `APC_OFS_MUTE: st_d.mute = st_q.sh;
                `APC_OFS_FLAGS: clr = ~st_q.sh[3:0];
                `APC_OFS_AM_CTL: st_d.am_ctl = st_q.sh;
                // unmapped sub-addresses are acknowledged but hold nothing
                default: clr = 4'h0;
              endcase
            end
          endcase
        end
      end
    end

    // sticky energy flags; a new event beats a clear in the same cycle
    evt[`APC_FLG_SAT_LOW] = sat_low_evt;
    evt[`APC_FLG_SAT_HIGH] = sat_high_evt;
    evt[`APC_FLG_SUB_LOW] = sub_low_evt;
    evt[`APC_FLG_SUB_HIGH] = sub_high_evt;
    // the host clears a flag by writing zero to its bit; ones leave it alone
    st_d.flags = (st_q.flags & ~clr) | evt;

    // headphone back end: reset request passes only when enabled
    st_d.hp_go = hp_backend_reset_req & st_q.hp_cfg[`APC_HP_BKND_RST_BIT];
    // valid stays low in headphone mode whenever the polarity bit is set
    st_d.hp_valid = hp_mode & hp_switching & ~st_q.hp_cfg[`APC_HP_VALID_LOW_BIT];

    // threshold follows its code; level compare is against full scale
    // reserved threshold codes are kept as written but act as -42 dBFS
    st_d.thr = thr_dec(st_q.am_ctl[7:4]);
    quiet = $signed(in_level_dbfs) < $signed(st_q.thr);

    // automute timer on a 1.49 ms step, so delays are exact to one step
    // the step counter runs free: a quiet spell may begin anywhere in a step, so
    // the delay seen at the output is the coded one plus at most one more step
    tick_wrap = st_q.tick == 16'(AM_STEP_CYCLES - 1);
    if (tick_wrap) begin
      // last cycle of a step
      st_d.tick = 16'h0000;
    end else begin
      // still inside the step
      st_d.tick = st_q.tick + 16'h0001;
    end
    if (!quiet) begin
      // any loud cycle restarts the wait and lifts the mute at once
      st_d.am_cnt = 7'h00;
      st_d.am_on = 1'b0;
    end else if (tick_wrap) begin
      // count whole quiet steps; the count stops once the mute is on
      if (st_q.am_cnt >= delay_steps(st_q.am_ctl[3:0])) begin
        st_d.am_on = 1'b1;
      end else begin
        st_d.am_cnt = st_q.am_cnt + 7'h01;
      end
    end

    // synchronous reset to the documented defaults
    if (rst) begin
      // everything not named below, flags and counters included, clears to zero
      st_d = '0;
      // pin copies rest at the idle bus level so that no false edge follows reset
      st_d.scl_a = 1'b1;
      st_d.scl_b = 1'b1;
      st_d.scl_p = 1'b1;
      st_d.sda_a = 1'b1;
      st_d.sda_b = 1'b1;
      st_d.sda_p = 1'b1;
      st_d.ph = apc_pkg::I2C_IDLE;
      st_d.hp_cfg = `APC_RST_HP_CFG;
      st_d.ser_fmt = `APC_RST_SER_FMT;
      // the decoded copies agree with the reset codes from the first cycle on
      st_d.fmt = fmt_dec(4'(`APC_RST_SER_FMT));
      st_d.mute = `APC_RST_MUTE;
      st_d.am_ctl = `APC_RST_AM_CTL;
      st_d.thr = thr_dec(4'(`APC_RST_AM_CTL >> 4));
    end
  end

  // single state register
  // no reset term here: the synchronous reset sits in the next-state logic
  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // outputs, all but the constant sda_out straight from state flops
  // open drain: the data pin is only ever pulled low, never driven high
  assign sda_out = 1'b0;
  assign sda_oe = st_q.sda_drv;
  assign hp_backend_reset_go = st_q.hp_go;
  assign hp_valid = st_q.hp_valid;
  assign channel_mute = st_q.mute;
  // one format drives both serial ports
  assign serial_audio_out_fmt = st_q.fmt;
  assign fifth_serial_audio_in_fmt = st_q.fmt;
  // the level compare uses the same registered threshold that leaves the block
  assign automute_threshold_dbfs = st_q.thr;
  assign automute_active = st_q.am_on;

endmodule

// *** apc_host_model.sv ***
// host model for the control port: drives the clock pin and pulls the data line.
// assumes a pull-up on the data line and a device that pulls it through its enable.
`timescale 1ns/100ps
module apc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input logic clk,
  input logic dev_pull,
  output logic scl,
  output logic sda
);
  logic hp = 1'b0; // host pulls the data line low
  logic ack; // last acknowledge seen from the device
  initial scl = 1'b1;
  // open drain: released line floats high through the pull-up
  assign sda = !(hp || dev_pull);
  // every change lands just after a clock edge
  task automatic q(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one bit: data set while clock low, sampled at the end of the high phase
  task automatic bt(input logic b, output logic r);
    hp = !b;
    q(5);
    scl = 1'b1;
    q(6);
    r = sda;
    scl = 1'b0;
    q(1);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    hp = 1'b0;
    q(5);
    scl = 1'b1;
    q(6);
    hp = 1'b1;
    q(6);
    scl = 1'b0;
    q(1);
  endtask
  task automatic stop();
    hp = 1'b1;
    q(5);
    scl = 1'b1;
    q(6);
    hp = 1'b0;
    q(6);
  endtask
  // bytes go msb first, then the device answers in the ninth bit
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(1'b1, r); // nack ends the read
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    start();
    tx({DEV_ADDR, 1'b0});
    tx(sub);
    tx(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    start();
    tx({DEV_ADDR, 1'b0});
    tx(sub);
    start();
    tx({DEV_ADDR, 1'b1});
    rx(d);
    stop();
  endtask
endmodule

// *** apc_regs_sva.sv ***
// checker of port relations of the audio pwm control registers.
// assumes it is bound to apc_regs and sees only its ports.
`timescale 1ns/100ps
`include "apc_params.svh"
module apc_regs_sva #(
  parameter int unsigned AM_STEP_CYCLES = `APC_AM_STEP_NS / `APC_CLK_NS
) (
  input logic clk,
  input logic rst,
  input logic scl_in,
  input logic sda_oe,
  input logic hp_mode,
  input logic hp_switching,
  input logic hp_backend_reset_req,
  input logic hp_backend_reset_go,
  input logic hp_valid,
  input logic [7:0] channel_mute,
  input apc_pkg::apc_fmt_type serial_audio_out_fmt,
  input apc_pkg::apc_fmt_type fifth_serial_audio_in_fmt,
  input logic signed [7:0] in_level_dbfs,
  input logic signed [7:0] automute_threshold_dbfs,
  input logic automute_active
);
  logic [31:0] quiet_q; // consecutive quiet cycles, bounds the automute delay
  // count quiet cycles; any loud cycle restarts the count, a long silence saturates
  always_ff @(posedge clk) begin
    if (rst || in_level_dbfs >= automute_threshold_dbfs) begin
      quiet_q <= 32'h00000000;
    end else if (quiet_q != 32'hFFFFFFFF) begin
      quiet_q <= quiet_q + 32'h00000001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_go_cause; hp_backend_reset_go |-> $past(hp_backend_reset_req); endproperty
  a_go_cause: assert property (p_go_cause) else $error("reset go without request");
  property p_valid_cause; hp_valid |-> $past(hp_mode && hp_switching); endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("valid without switching");
  property p_fmt_same; serial_audio_out_fmt == fifth_serial_audio_in_fmt; endproperty
  a_fmt_same: assert property (p_fmt_same) else $error("serial formats differ");
  property p_fmt_legal; serial_audio_out_fmt.word_bits inside {5'h10, 5'h14, 5'h18}; endproperty
  a_fmt_legal: assert property (p_fmt_legal) else $error("word length illegal");
  property p_thr_legal;
    automute_threshold_dbfs inside {8'hA6, 8'hAC, 8'hB2, 8'hB8, 8'hBE, 8'hC4, 8'hCA, 8'hD0, 8'hD6};
  endproperty
  a_thr_legal: assert property (p_thr_legal) else $error("threshold off the grid");
  property p_mute_sync; $changed(channel_mute) |-> !scl_in; endproperty
  a_mute_sync: assert property (p_mute_sync) else $error("mute changed with clock high");
  property p_ack_low; $rose(sda_oe) |-> !scl_in; endproperty
  a_ack_low: assert property (p_ack_low) else $error("data pulled with clock high");
  property p_am_clear; (in_level_dbfs >= automute_threshold_dbfs) |-> ##2 !automute_active; endproperty
  a_am_clear: assert property (p_am_clear) else $error("automute held while loud");
  property p_am_delay; $rose(automute_active) |-> quiet_q > 2 * AM_STEP_CYCLES; endproperty
  a_am_delay: assert property (p_am_delay) else $error("automute too early");
  c_am: cover property ($rose(automute_active));
  c_go: cover property ($rose(hp_backend_reset_go));
  c_mute: cover property ($changed(channel_mute));
endmodule

bind apc_regs apc_regs_sva #(.AM_STEP_CYCLES(AM_STEP_CYCLES)) u_sva (.clk, .rst, .scl_in, .sda_oe, .hp_mode,
  .hp_switching, .hp_backend_reset_req, .hp_backend_reset_go, .hp_valid, .channel_mute, .serial_audio_out_fmt,
  .fifth_serial_audio_in_fmt, .in_level_dbfs, .automute_threshold_dbfs, .automute_active);

// *** apc_regs_tb_top.sv ***
// self-checking bench of the audio pwm control registers through the host model.
// assumes the design, its checker and the host model are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; $display("wrong value at %0t: got %0h expected %0h", $time, a, e); end end
module apc_regs_tb_top;
  localparam int unsigned STEP = 10; // shortened automute step keeps the run short
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, sda_out, sda_oe, go, valid, am;
  logic hp_mode = 1'b0, hp_sw = 1'b0, req = 1'b0;
  logic [3:0] evt = 4'h0; // energy events, bit order of the flag register
  logic [3:0] prev;
  logic [7:0] mute, got, val;
  logic [7:0] ofs[6] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h14, 8'h11}; // last one is unmapped
  logic [7:0] rvl[6] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [3:0] dly[4] = '{4'h0, 4'h3, 4'h4, 4'hF};
  apc_pkg::apc_fmt_type fmt_out, fmt_in;
  logic signed [7:0] level = 8'h7F, thr; // loud until a test wants silence
  int n_errors = 0, compares = 0, seed = 84455, s;
  apc_regs #(.AM_STEP_CYCLES(STEP)) DUT (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hp_mode(hp_mode), .hp_switching(hp_sw), .hp_backend_reset_req(req),
    .hp_backend_reset_go(go), .hp_valid(valid), .sat_low_evt(evt[0]), .sat_high_evt(evt[1]),
    .sub_low_evt(evt[2]), .sub_high_evt(evt[3]), .channel_mute(mute), .serial_audio_out_fmt(fmt_out),
    .fifth_serial_audio_in_fmt(fmt_in), .in_level_dbfs(level), .automute_threshold_dbfs(thr),
    .automute_active(am));
  apc_host_model host (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  initial forever #20 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // expected format: three justifications, each at 16, 20 and 24 bits
  function automatic apc_pkg::apc_fmt_type fmt_exp(input logic [3:0] c);
    fmt_exp = '{apc_pkg::apc_justify_type'(2'(c / 4'h3)), 5'(5'h10 + 5'h04 * 5'(c % 4'h3))};
  endfunction
  function automatic logic [7:0] thr_exp(input logic [3:0] c);
    thr_exp = (c == 4'h8) ? 8'hD6 : 8'hA6 + 8'h06 * 8'(c);
  endfunction
  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // cut a hang short well beyond the expected run
  initial begin
    cyc(80000);
    n_errors++;
    conclude();
  end
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(3);
    host.wr(8'h11, 8'hFF); // unmapped write must leave nothing behind
    `CHK(host.ack, 1'b1)
    foreach (ofs[i]) begin
      host.rd(ofs[i], got);
      `CHK(got, rvl[i])
    end
    `CHK(thr, 8'hA6)
    // a foreign address gets no acknowledge and the line is never driven high
    host.start();
    host.tx(8'h20);
    host.stop();
    `CHK(host.ack, 1'b0)
    `CHK(sda_out, 1'b0)
    $display("test reset done");
    prev = 4'h5;
    // every code, legal ones stored, illegal ones refused
    for (int c = 0; c < 16; c++) begin
      host.wr(8'h0E, 8'(c));
      if (c < 9) prev = 4'(c);
      host.rd(8'h0E, got);
      `CHK(got, {4'h0, prev})
      `CHK(fmt_out, fmt_exp(prev))
      `CHK(fmt_in, fmt_exp(prev))
    end
    $display("test serial format done");
    for (int i = 0; i < 5; i++) begin
      val = (i == 0) ? 8'h80 : ((i == 4) ? 8'h00 : 8'($random(seed)));
      host.wr(8'h0F, val);
      host.rd(8'h0F, got);
      `CHK(got, val)
      `CHK(mute, val)
    end
    $display("test soft mute done");
    // all four settings of the reset-enable and valid-polarity bits
    for (int i = 0; i < 4; i++) begin
      val = 8'($random(seed));
      val[7:6] = 2'(i);
      host.wr(8'h0D, val);
      host.rd(8'h0D, got);
      `CHK(got, val & 8'hFE)
      hp_mode = 1'b1;
      hp_sw = 1'b1;
      req = 1'b1;
      cyc(1);
      `CHK(go, val[7])
      `CHK(valid, !val[6])
      hp_sw = 1'b0;
      req = 1'b0;
      cyc(1);
      `CHK(valid, 1'b0)
      hp_mode = 1'b0;
    end
    $display("test headphone done");
    // each flag alone, then sticky behaviour under partial clears
    for (int b = 0; b < 4; b++) begin
      evt = 4'(1 << b);
      cyc(1);
      evt = 4'h0;
      host.rd(8'h10, got);
      `CHK(got, 8'(1 << b))
      host.wr(8'h10, 8'h00);
    end
    evt = 4'hF;
    cyc(1);
    evt = 4'h0;
    host.wr(8'h10, 8'h0A);
    host.rd(8'h10, got);
    `CHK(got, 8'h0A)
    // an event held through the clearing write wins over the clear
    evt = 4'h4;
    host.wr(8'h10, 8'h00);
    evt = 4'h0;
    host.rd(8'h10, got);
    `CHK(got, 8'h04)
    $display("test energy flags done");
    for (int c = 0; c < 9; c++) begin
      host.wr(8'h14, {4'(c), 4'h0});
      cyc(2);
      `CHK(thr, thr_exp(4'(c)))
    end
    $display("test threshold done");
    // silence below a -42 threshold for each delay, then a level of -42 that stays loud
    foreach (dly[i]) begin
      host.wr(8'h14, {4'h8, dly[i]});
      s = (dly[i] < 4'h4) ? int'(dly[i]) + 2 : (int'(dly[i]) - 3) * 10;
      level = 8'hC0;
      cyc(s * STEP);
      `CHK(am, 1'b0)
      cyc(STEP + 5);
      `CHK(am, 1'b1)
      level = 8'hD6;
      cyc(2);
      `CHK(am, 1'b0)
    end
    $display("test automute done");
    conclude();
  end
endmodule
